// ===== src/adc_scan_fifo_sequencer.sv
// converter sequencer with scan, trigger select, sample fifo and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_scan_fifo_sequencer (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_trig_in,
   input wire logic ext_trig_in,
   input wire logic conv_done_in,
   input wire logic [15:0] conv_data_in,
   output logic conv_start_out,
   output logic [3:0] conv_channel_out,
   output logic irq_out
);
   // ************************************************************
   // declarations
   // ************************************************************
   adc_seq_pkg::pins_t pins_raw;
   adc_seq_pkg::pins_t pins_s;
   adc_seq_pkg::ctrl_t ctrl_reg;
   adc_seq_pkg::chan_range_t range_reg;
   adc_seq_pkg::seq_state_t state_reg;
   adc_seq_pkg::seq_state_t state_next;
   logic [`THRESH_W-1:0] thresh_reg;
   logic [15:0] sample_reg;
   logic ovf_reg;
   logic trig_sel_prev_reg;
   logic [5:0] aw_idx_reg;
   logic aw_ok_reg;
   logic [7:0] w_byte_reg;
   logic w_lane_reg;
   logic [5:0] wr_idx;
   logic do_write;
   logic wr_clear;
   logic sw_trig;
   logic trig_sel_level;
   logic hw_trig;
   logic start_cycle;
   logic accept_sample;
   logic fifo_push;
   logic [7:0] fifo_push_data;
   logic fifo_pop;
   logic [7:0] fifo_head;
   logic [`FIFO_AW-1:0] fifo_count;
   logic [5:0] fill_samples;
   logic ar_take;
   logic [5:0] ar_idx;
   logic [31:0] rd_word;
   logic rd_ok;

   function automatic logic [5:0] addr_idx(input logic [7:0] a);
      addr_idx = a[7:2];
   endfunction : addr_idx

   function automatic logic idx_mapped(input logic [5:0] i);
      idx_mapped = (i <= `IDX_DEPTH);
   endfunction : idx_mapped

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   assign pins_raw = '{conv_done: conv_done_in, conv_data: conv_data_in,
                       timer_trig: timer_trig_in, ext_trig: ext_trig_in};

   pin_sync #(.W($bits(adc_seq_pkg::pins_t))) u_pin_sync (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .d_in(pins_raw),
      .q_out(pins_s)
   );

   // ************************************************************
   // sample fifo
   // ************************************************************
   byte_fifo u_fifo (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .clear_in(wr_clear),
      .push_in(fifo_push),
      .push_data_in(fifo_push_data),
      .pop_in(fifo_pop),
      .head_out(fifo_head),
      .count_out(fifo_count)
   );

   assign fill_samples = fifo_count[`FIFO_AW-1:1];

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   assign wr_idx = aw_idx_reg;
   assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_clear = do_write && aw_ok_reg && w_lane_reg && (wr_idx == `IDX_DATA_HI)
                     && w_byte_reg[`BIT_FIFO_CLEAR];
   assign sw_trig = do_write && aw_ok_reg && (wr_idx == `IDX_DATA_LO)
                    && !ctrl_reg.acq_interrupt_enable;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_awready <= 1'b1;
         aw_idx_reg <= '0;
         aw_ok_reg <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_idx_reg <= addr_idx(s_axi_awaddr);
         aw_ok_reg <= idx_mapped(addr_idx(s_axi_awaddr));
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_wready <= 1'b1;
         w_byte_reg <= '0;
         w_lane_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_byte_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= aw_ok_reg ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_reg <= '0;
      end else if (do_write && aw_ok_reg && w_lane_reg) begin
         if (wr_idx == `IDX_STATUS) begin
            ctrl_reg.scan_enable_bit <= w_byte_reg[`BIT_SCAN];
         end
         if (wr_idx == `IDX_CTRL) begin
            ctrl_reg.acq_interrupt_enable <= w_byte_reg[`BIT_IE];
            ctrl_reg.trigger_source_select <= w_byte_reg[`BIT_TSEL];
         end
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         range_reg <= `CHAN_RESET;
      end else if (do_write && aw_ok_reg && w_lane_reg && (wr_idx == `IDX_CHAN)) begin
         range_reg <= w_byte_reg;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         thresh_reg <= `THRESH_RESET;
      end else if (do_write && aw_ok_reg && w_lane_reg && (wr_idx == `IDX_THRESH)) begin
         thresh_reg <= w_byte_reg[`THRESH_W-1:0];
      end
   end

   // ************************************************************
   // trigger selection
   // ************************************************************
   assign trig_sel_level = ctrl_reg.trigger_source_select ? pins_s.ext_trig : pins_s.timer_trig;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         trig_sel_prev_reg <= 1'b0;
      end else begin
         trig_sel_prev_reg <= trig_sel_level;
      end
   end

   assign hw_trig = ctrl_reg.acq_interrupt_enable && trig_sel_level && !trig_sel_prev_reg;
   assign start_cycle = (state_reg == adc_seq_pkg::ST_IDLE) && (sw_trig || hw_trig);

   // ************************************************************
   // conversion sequencer
   // ************************************************************
   assign accept_sample = !ovf_reg && (fifo_count <= 7'(`FIFO_ENTRIES - 2));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         adc_seq_pkg::ST_IDLE: begin
            if (start_cycle) begin
               state_next = adc_seq_pkg::ST_ARM;
            end
         end
         adc_seq_pkg::ST_ARM: begin
            if (!pins_s.conv_done) begin
               state_next = adc_seq_pkg::ST_WAIT;
            end
         end
         adc_seq_pkg::ST_WAIT: begin
            if (pins_s.conv_done) begin
               state_next = adc_seq_pkg::ST_PUSH_LO;
            end
         end
         adc_seq_pkg::ST_PUSH_LO: begin
            state_next = accept_sample ? adc_seq_pkg::ST_PUSH_HI : adc_seq_pkg::ST_STEP;
         end
         adc_seq_pkg::ST_PUSH_HI: begin
            state_next = adc_seq_pkg::ST_STEP;
         end
         adc_seq_pkg::ST_STEP: begin
            if (ctrl_reg.scan_enable_bit && (conv_channel_out != range_reg.high)) begin
               state_next = adc_seq_pkg::ST_ARM;
            end else begin
               state_next = adc_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = adc_seq_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= adc_seq_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_start_out <= 1'b0;
      end else if (state_reg == adc_seq_pkg::ST_ARM && !pins_s.conv_done) begin
         conv_start_out <= 1'b1;
      end else if (state_reg == adc_seq_pkg::ST_WAIT && pins_s.conv_done) begin
         conv_start_out <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_reg <= '0;
      end else if (state_reg == adc_seq_pkg::ST_WAIT && pins_s.conv_done) begin
         sample_reg <= pins_s.conv_data;
      end
   end

   // current channel, stepped after each conversion
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_channel_out <= '0;
      end else if (do_write && aw_ok_reg && w_lane_reg && (wr_idx == `IDX_CHAN)) begin
         conv_channel_out <= w_byte_reg[3:0];
      end else if (state_reg == adc_seq_pkg::ST_STEP) begin
         if (conv_channel_out == range_reg.high) begin
            conv_channel_out <= range_reg.low;
         end else begin
            conv_channel_out <= conv_channel_out + 4'h1;
         end
      end
   end

   // ************************************************************
   // fifo feed and overflow
   // ************************************************************
   assign fifo_push = ((state_reg == adc_seq_pkg::ST_PUSH_LO) && accept_sample)
                      || (state_reg == adc_seq_pkg::ST_PUSH_HI);
   assign fifo_push_data = (state_reg == adc_seq_pkg::ST_PUSH_HI) ? sample_reg[15:8]
                                                                  : sample_reg[7:0];

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ovf_reg <= 1'b0;
      end else if (state_reg == adc_seq_pkg::ST_PUSH_LO && !accept_sample) begin
         ovf_reg <= 1'b1;
      end else if (wr_clear) begin
         ovf_reg <= 1'b0;
      end
   end

   // ************************************************************
   // interrupt request
   // ************************************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= ctrl_reg.acq_interrupt_enable && (thresh_reg != '0)
                    && (fill_samples >= thresh_reg);
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign ar_idx = addr_idx(s_axi_araddr);
   assign fifo_pop = ar_take && ((ar_idx == `IDX_DATA_LO) || (ar_idx == `IDX_DATA_HI));

   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      unique case (ar_idx)
         `IDX_DATA_LO, `IDX_DATA_HI: begin
            rd_word[7:0] = fifo_head;
         end
         `IDX_CHAN: begin
            rd_word[7:0] = range_reg;
         end
         `IDX_STATUS: begin
            rd_word[`BIT_BUSY] = (state_reg != adc_seq_pkg::ST_IDLE);
            rd_word[`BIT_OVF] = ovf_reg;
            rd_word[`BIT_SCAN] = ctrl_reg.scan_enable_bit;
         end
         `IDX_CTRL: begin
            rd_word[`BIT_IE] = ctrl_reg.acq_interrupt_enable;
            rd_word[`BIT_TSEL] = ctrl_reg.trigger_source_select;
         end
         `IDX_THRESH: begin
            rd_word[`THRESH_W-1:0] = thresh_reg;
         end
         `IDX_DEPTH: begin
            rd_word[`FIFO_AW-1:0] = fifo_count;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : adc_scan_fifo_sequencer
`default_nettype wire

// ===== src/adc_seq_params.svh
// register indexes, field positions and sizes of the acquisition sequencer
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register indexes; the byte address is four times the index
`define IDX_DATA_LO 6'h00
`define IDX_DATA_HI 6'h01
`define IDX_CHAN 6'h02
`define IDX_STATUS 6'h03
`define IDX_CTRL 6'h04
`define IDX_THRESH 6'h05
`define IDX_DEPTH 6'h06

// field positions
`define BIT_FIFO_CLEAR 0
`define BIT_SCAN 2
`define BIT_OVF 6
`define BIT_BUSY 7
`define BIT_IE 0
`define BIT_TSEL 4

// sizes and reset values
`define FIFO_ENTRIES 96
`define FIFO_AW 7
`define FIFO_LAST 7'h5F
`define THRESH_W 6
`define CHAN_RESET 8'h00
`define THRESH_RESET 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/adc_seq_pkg.sv
// types shared by the acquisition sequencer files
package adc_seq_pkg;

   typedef struct packed {
      logic [3:0] high;
      logic [3:0] low;
   } chan_range_t;

   typedef struct packed {
      logic trigger_source_select;
      logic acq_interrupt_enable;
      logic scan_enable_bit;
   } ctrl_t;

   typedef struct packed {
      logic conv_done;
      logic [15:0] conv_data;
      logic timer_trig;
      logic ext_trig;
   } pins_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ARM = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_PUSH_LO = 6'b001000,
      ST_PUSH_HI = 6'b010000,
      ST_STEP = 6'b100000
   } seq_state_t;

endpackage : adc_seq_pkg

// ===== src/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ===== src/byte_fifo.sv
// byte-wide sample store with fill count
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module byte_fifo (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic clear_in,
   input wire logic push_in,
   input wire logic [7:0] push_data_in,
   input wire logic pop_in,
   output logic [7:0] head_out,
   output logic [`FIFO_AW-1:0] count_out
);
   logic [7:0] mem [0:`FIFO_ENTRIES-1];
   logic [`FIFO_AW-1:0] wr_ptr_reg;
   logic [`FIFO_AW-1:0] rd_ptr_reg;
   logic [`FIFO_AW-1:0] count_reg;
   logic do_push;
   logic do_pop;

   function automatic logic [`FIFO_AW-1:0] ptr_inc(input logic [`FIFO_AW-1:0] p);
      ptr_inc = (p == `FIFO_LAST) ? '0 : p + 7'h01;
   endfunction : ptr_inc

   assign do_push = push_in && (count_reg != 7'(`FIFO_ENTRIES));
   assign do_pop = pop_in && (count_reg != '0);
   assign head_out = mem[rd_ptr_reg];
   assign count_out = count_reg;

   always_ff @(posedge clock_in) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= push_data_in;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (clear_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (do_pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (do_push && !do_pop) begin
            count_reg <= count_reg + 7'h01;
         end else if (do_pop && !do_push) begin
            count_reg <= count_reg - 7'h01;
         end
      end
   end
endmodule : byte_fifo
`default_nettype wire

// ===== testbench/adc_seq_asserts.sv
// port assertions for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic conv_done_in,
   input wire logic conv_start_out,
   input wire logic [3:0] conv_channel_out,
   input wire logic irq_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_done_held;
      (conv_start_out && conv_done_in) [*3];
   endsequence
   a_start_until_done: assert property (conv_start_out && !conv_done_in |=> conv_start_out)
      else $error("start dropped before done");
   a_start_drop_bound: assert property (s_done_held |=> !conv_start_out)
      else $error("start held after done");
   a_push_gap: assert property ($fell(conv_start_out) |-> !conv_start_out [*3])
      else $error("no room for two byte pushes");
   a_chan_steady: assert property (conv_start_out && $past(conv_start_out) |-> $stable(conv_channel_out))
      else $error("channel moved during conversion");
   a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_aw_blocked: assert property (s_wr_take |=> !s_axi_awready until (s_axi_bvalid && s_axi_bready))
      else $error("second write address accepted");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h06
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_irq_fresh: assert property ($rose(irq_out) |-> !($past(s_axi_arvalid) && $past(s_axi_arready)))
      else $error("read raised interrupt");
endmodule : adc_seq_asserts
bind adc_scan_fifo_sequencer adc_seq_asserts i_adc_seq_asserts (.clock_in(clock_in), .arst_n_in(arst_n_in),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .conv_done_in(conv_done_in), .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
   .irq_out(irq_out));
`default_nettype wire

// ===== testbench/conv_model.sv
// behavioural model of the external converter chip
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic start_in,
   input wire logic [3:0] chan_in,
   input wire logic [7:0] delay_in,
   output logic done_out,
   output logic [15:0] data_out
);
   logic [7:0] wait_reg;
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_out <= 1'b0;
         data_out <= 16'hFFFF;
         wait_reg <= 8'h00;
      end else if (start_in && !done_out) begin
         if (wait_reg >= delay_in) begin
            done_out <= 1'b1;
            data_out <= {4'hC, chan_in, 4'h3, chan_in};
            wait_reg <= 8'h00;
         end else begin
            wait_reg <= wait_reg + 8'h01;
         end
      end else if (!start_in && done_out) begin
         done_out <= 1'b0;
         data_out <= ~data_out; // released: result no longer valid
      end
   end
endmodule : conv_model
`default_nettype wire

// ===== testbench/adc_scan_fifo_sequencer_test.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module adc_scan_fifo_sequencer_test;
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic timer_trig = 1'b0, ext_trig = 1'b0;
   logic [7:0] conv_delay = 8'h14;
   logic awready, wready, bvalid, arready, rvalid, conv_start, irq, conv_done;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [15:0] conv_data;
   logic [3:0] conv_ch;
   int error_cnt = 0;
   int n_checks = 0;
   always #4 clock_in = ~clock_in;
   adc_scan_fifo_sequencer i_adc_scan_fifo_sequencer (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_trig_in(timer_trig), .ext_trig_in(ext_trig), .conv_done_in(conv_done),
      .conv_data_in(conv_data), .conv_start_out(conv_start), .conv_channel_out(conv_ch), .irq_out(irq));
   conv_model i_conv_model (.clock_in(clock_in), .arst_n_in(arst_n_in), .start_in(conv_start),
      .chan_in(conv_ch), .delay_in(conv_delay), .done_out(conv_done), .data_out(conv_data));
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [5:0] idx, input logic [31:0] v);
      @(posedge clock_in);
      awaddr <= {idx, 2'b00};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("write response", (idx > `IDX_DEPTH) ? `RESP_SLVERR : `RESP_OKAY, bresp)
   endtask : wr
   task automatic rd(input logic [5:0] idx);
      @(posedge clock_in);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock_in);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask : rd
   task automatic chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      rd(idx);
      `CHK(what, exp, d)
   endtask : chk
   task automatic sample(input logic [3:0] ch);
      chk("low byte", `IDX_DATA_LO, {24'h0, 4'h3, ch});
      chk("high byte", `IDX_DATA_HI, {24'h0, 4'hC, ch});
   endtask : sample
   task automatic wait_idle();
      do begin
         rd(`IDX_STATUS);
      end while (d[`BIT_BUSY] !== 1'b0);
   endtask : wait_idle
   task automatic pulse(input logic sel);
      @(posedge clock_in);
      if (sel) ext_trig <= 1'b1;
      else timer_trig <= 1'b1;
      repeat (4) @(posedge clock_in);
      timer_trig <= 1'b0;
      ext_trig <= 1'b0;
   endtask : pulse
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (60000) @(posedge clock_in);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clock_in);
      arst_n_in <= 1'b1;
      for (int i = 2; i < 7; i++) chk("reset value", 6'(i), 32'h0);
      rd(6'h07);
      `CHK("unmapped resp", 2'h2, r)
      wr(6'h07, 32'hFF);
      chk("unmapped write no effect", `IDX_CTRL, 32'h0);
      wr(`IDX_CHAN, 32'h31);
      `CHK("load low channel", 4'h1, conv_ch)
      wr(`IDX_DATA_LO, 32'h0);
      chk("busy", `IDX_STATUS, 32'h80);
      wait_idle();
      chk("depth", `IDX_DEPTH, 32'h2);
      sample(4'h1);
      `CHK("next channel", 4'h2, conv_ch)
      `CHK("irq", 1'b0, irq)
      conv_delay <= 8'h02;
      wr(`IDX_STATUS, 32'h4);
      wr(`IDX_CHAN, 32'h31);
      wr(`IDX_DATA_LO, 32'h0);
      wait_idle();
      chk("scan depth", `IDX_DEPTH, 32'h6);
      for (int c = 1; c < 4; c++) sample(4'(c));
      `CHK("wrapped channel", 4'h1, conv_ch)
      `CHK("irq", 1'b0, irq)
      wr(`IDX_STATUS, 32'h0);
      wr(`IDX_THRESH, 32'h1);
      for (int s = 0; s < 2; s++) begin
         wr(`IDX_CTRL, (s == 1) ? 32'h11 : 32'h01);
         wr(`IDX_DATA_LO, 32'h0);
         pulse(s == 0);
         wait_idle();
         chk("ignored triggers", `IDX_DEPTH, 32'h0);
         `CHK("irq", 1'b0, irq)
         pulse(s == 1);
         wait_idle();
         chk("triggered", `IDX_DEPTH, 32'h2);
         `CHK("irq", 1'b1, irq)
         sample(4'(s + 1));
         chk("drained", `IDX_DEPTH, 32'h0);
         `CHK("irq", 1'b0, irq)
      end
      wr(`IDX_CTRL, 32'h0);
      wr(`IDX_THRESH, 32'h10);
      wr(`IDX_STATUS, 32'h4);
      wr(`IDX_CHAN, 32'hF0);
      for (int k = 0; k < 4; k++) begin
         wr(`IDX_DATA_LO, 32'h0);
         wait_idle();
      end
      chk("overflow status", `IDX_STATUS, 32'h44);
      chk("full depth", `IDX_DEPTH, 32'h60);
      `CHK("irq", 1'b0, irq)
      sample(4'h0);
      wr(`IDX_DATA_HI, 32'h1);
      chk("cleared depth", `IDX_DEPTH, 32'h0);
      chk("cleared status", `IDX_STATUS, 32'h4);
      report_and_stop();
   end
endmodule : adc_scan_fifo_sequencer_test
`default_nettype wire
